/* core/hdc_regs.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef HDC_REGS_VH
`define HDC_REGS_VH
// ======================================================================
// Register map
`define HDC_ADDR_W 8
`define HDC_DRIVE_CTRL_ADDR 8'h1b
`define HDC_FEEDBACK_CTRL_ADDR 8'h1a
// ======================================================================
// Field positions
`define HDC_BOOST_BIT 7
`define HDC_CM_DRIVE_BIT 5
`define HDC_DT_MSB 4
`define HDC_DT_LSB 0
`define HDC_TYPE_BIT 7
// ======================================================================
// Reset values and write mask
`define HDC_DRIVE_CTRL_RST 8'h93
`define HDC_DRIVE_CTRL_MASK 8'hbf
`define HDC_TYPE_RST 1'b0
// ======================================================================
// Timing, in microseconds and in clock cycles, and clock rate
`define HDC_CLK_MHZ 125
`define HDC_LRA_STEP_US 100
`define HDC_LRA_BASE_US 500
`define HDC_ERM_STEP_US 200
`define HDC_ERM_BASE_US 1000
`define HDC_ADJ_LIMIT_US 3100
`define HDC_ADJ_STEP_CYC 24'h00000c
`define HDC_ADJ_MIN_CYC 24'h000001
`endif

/* core/hdc_period_timer.v */
// Period timer that pulses once per programmed interval
module hdc_period_timer (
  // Clock and reset
  input wire clk_sys,
  input wire nrst,
  // Interval in cycles
  input wire [23:0] period_cycles,
  // Tick out
  output reg tick
);
  reg [23:0] count;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count <= 24'h000000;
      tick <= 1'b0;
    end else if (count + 24'h000001 >= period_cycles) begin
      count <= 24'h000000;
      tick <= 1'b1;
    end else begin
      count <= count + 24'h000001;
      tick <= 1'b0;
    end
  end
endmodule // hdc_period_timer

/* core/hdc_drive_control.v */
// Actuator drive control register and the timing it steers
`include "hdc_regs.vh"
module hdc_drive_control (
  // Clock and reset
  input wire clk_sys,
  input wire nrst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Engine status
  input wire overdrive_phase,
  input wire resonance_early,
  input wire resonance_late,
  // Drive outputs
  output reg input_trigger_pin_bias_en,
  output reg high_loop_gain,
  output reg actuator_type_select,
  output reg [23:0] drive_half_period,
  output reg [23:0] bemf_sample_period,
  output reg bemf_sample_tick
);
  // ====================================================================
  // Time conversion
  function [23:0] us_to_cycles;
    input [31:0] us;
    reg [31:0] product;
    begin
      product = us * `HDC_CLK_MHZ;
      us_to_cycles = product[23:0];
    end
  endfunction

  function [23:0] field_cycles;
    input [4:0] field;
    input [31:0] step_us;
    input [31:0] base_us;
    begin
      field_cycles = us_to_cycles({27'h0, field} * step_us + base_us);
    end
  endfunction

  // ====================================================================
  // Address decode and read mux
  function addr_is_ctrl;
    input [7:0] addr;
    begin
      addr_is_ctrl = (addr == `HDC_DRIVE_CTRL_ADDR);
    end
  endfunction

  function addr_is_type;
    input [7:0] addr;
    begin
      addr_is_type = (addr == `HDC_FEEDBACK_CTRL_ADDR);
    end
  endfunction

  function [7:0] read_value;
    input [7:0] addr;
    input [7:0] ctrl;
    input sel;
    begin
      if (addr_is_ctrl(addr)) begin
        read_value = ctrl;
      end else if (addr_is_type(addr)) begin
        read_value = {sel, 7'h00};
      end else begin
        read_value = 8'h00;
      end
    end
  endfunction

  localparam [23:0] ADJ_STEP = `HDC_ADJ_STEP_CYC;
  localparam [23:0] ADJ_MIN = `HDC_ADJ_MIN_CYC;

  // ====================================================================
  // Registers
  reg [7:0] drive_ctrl;
  reg type_sel;
  reg [4:0] last_field;
  reg last_type;
  wire [4:0] drive_time_field = drive_ctrl[`HDC_DT_MSB:`HDC_DT_LSB];
  wire [23:0] lra_seed;
  wire [23:0] erm_period;
  wire [23:0] adj_max;
  wire sample_tick;
  reg [23:0] next_half;
  reg [7:0] next_drive_ctrl;
  reg next_type_sel;
  reg [7:0] next_rdata;

  assign lra_seed = field_cycles(drive_time_field, `HDC_LRA_STEP_US,
    `HDC_LRA_BASE_US);
  assign erm_period = field_cycles(drive_time_field, `HDC_ERM_STEP_US,
    `HDC_ERM_BASE_US);
  assign adj_max = us_to_cycles(`HDC_ADJ_LIMIT_US);

  // ====================================================================
  // Register write path
  always @* begin
    next_drive_ctrl = drive_ctrl;
    next_type_sel = type_sel;
    if (reg_wr && addr_is_ctrl(reg_addr)) begin
      next_drive_ctrl = reg_wdata & `HDC_DRIVE_CTRL_MASK;
    end
    if (reg_wr && addr_is_type(reg_addr)) begin
      next_type_sel = reg_wdata[`HDC_TYPE_BIT];
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drive_ctrl <= `HDC_DRIVE_CTRL_RST;
      type_sel <= `HDC_TYPE_RST;
    end else begin
      drive_ctrl <= next_drive_ctrl;
      type_sel <= next_type_sel;
    end
  end

  // ====================================================================
  // Register read path
  always @* begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      next_rdata = read_value(reg_addr, drive_ctrl, type_sel);
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ====================================================================
  // Resonant drive time tracking
  always @* begin
    next_half = drive_half_period;
    if (drive_time_field != last_field || type_sel != last_type) begin
      next_half = lra_seed;
    end else if (type_sel && resonance_early && drive_half_period > ADJ_STEP + ADJ_MIN) begin
      next_half = drive_half_period - ADJ_STEP;
    end else if (type_sel && resonance_late && drive_half_period < adj_max) begin
      next_half = drive_half_period + ADJ_STEP;
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drive_half_period <= 24'h000000;
      last_field <= 5'h1f;
      last_type <= 1'b1;
    end else begin
      drive_half_period <= next_half;
      last_field <= drive_time_field;
      last_type <= type_sel;
    end
  end

  // ====================================================================
  // Input pin bias
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      input_trigger_pin_bias_en <= 1'b0;
    end else begin
      input_trigger_pin_bias_en <= drive_ctrl[`HDC_CM_DRIVE_BIT];
    end
  end

  // ====================================================================
  // Overdrive loop gain
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      high_loop_gain <= 1'b0;
    end else begin
      high_loop_gain <= drive_ctrl[`HDC_BOOST_BIT] & overdrive_phase;
    end
  end

  // ====================================================================
  // Actuator type
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      actuator_type_select <= 1'b0;
    end else begin
      actuator_type_select <= type_sel;
    end
  end

  // ====================================================================
  // Back-EMF sampling period and tick
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bemf_sample_period <= 24'h000000;
      bemf_sample_tick <= 1'b0;
    end else begin
      bemf_sample_period <= erm_period;
      bemf_sample_tick <= sample_tick & ~type_sel;
    end
  end

  // ====================================================================
  // Back-EMF sampling timer
  hdc_period_timer u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .period_cycles(erm_period),
    .tick(sample_tick)
  );
endmodule // hdc_drive_control

/* verification/hdc_drive_control_properties.sv */
// Checker for the drive control register ports
`include "hdc_regs.vh"
module hdc_drive_control_properties (
  input wire clk_sys, nrst, reg_wr, reg_rd, overdrive_phase, high_loop_gain,
  input wire input_trigger_pin_bias_en, actuator_type_select, bemf_sample_tick,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire [23:0] drive_half_period, bemf_sample_period
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========
  // Properties
  sequence wr_ctl;
    reg_wr && reg_addr == `HDC_DRIVE_CTRL_ADDR;
  endsequence
  sequence rd_after_wr;
    wr_ctl ##1 (reg_rd && !reg_wr && reg_addr == `HDC_DRIVE_CTRL_ADDR);
  endsequence
  AST_BIAS: assert property (wr_ctl |-> ##2
    input_trigger_pin_bias_en == $past(reg_wdata[5], 2)) else $error("bias");
  AST_BEMF: assert property (wr_ctl |-> ##2 bemf_sample_period ==
    ($past(reg_wdata[4:0], 2) * 24'd200 + 24'd1000) * 24'd125) else $error("bemf");
  AST_GAIN: assert property (wr_ctl ##1 !reg_wr |=> high_loop_gain ==
    ($past(reg_wdata[7], 2) && $past(overdrive_phase))) else $error("gain");
  AST_READ: assert property (rd_after_wr |=> reg_rdata ==
    ($past(reg_wdata, 2) & `HDC_DRIVE_CTRL_MASK)) else $error("read back");
  AST_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("hold");
  AST_TYPE: assert property (reg_wr && reg_addr == 8'h1a |-> ##2
    actuator_type_select == $past(reg_wdata[7], 2)) else $error("type");
  AST_TICK: assert property (actuator_type_select [*3] |-> !bemf_sample_tick)
    else $error("tick");
  AST_SEED: assert property (actuator_type_select [*2] |->
    drive_half_period inside {[24'd2:24'd450000]}) else $error("half period");
endmodule // hdc_drive_control_properties

/* verification/test_hdc_drive_control.sv */
// Self-checking bench for the drive control register
`include "hdc_regs.vh"
module test_haptic_drive_control_reg;
  timeunit 1ns;
  timeprecision 1ps;
  reg clk_sys = 0, nrst = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0, overdrive_phase = 0;
  reg resonance_early = 0, resonance_late = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0, d;
  reg [23:0] exp_half;
  wire [7:0] reg_rdata;
  wire input_trigger_pin_bias_en, high_loop_gain, actuator_type_select, bemf_sample_tick;
  wire [23:0] drive_half_period, bemf_sample_period;
  logic [7:0] exp_q[$];
  int error_cnt = 0, n_compared = 0;
  hdc_drive_control dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .overdrive_phase(overdrive_phase),
    .resonance_early(resonance_early),
    .resonance_late(resonance_late),
    .input_trigger_pin_bias_en(input_trigger_pin_bias_en),
    .high_loop_gain(high_loop_gain),
    .actuator_type_select(actuator_type_select),
    .drive_half_period(drive_half_period),
    .bemf_sample_period(bemf_sample_period),
    .bemf_sample_tick(bemf_sample_tick)
  );
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) rd_seen <= reg_rd;
  // ==========
  // Tasks
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] ex);
    n_compared++;
    if (seen !== ex) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task end_of_test;
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task op(input logic w, r, input logic [7:0] a, wd, ex);
    @(negedge clk_sys);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = wd;
    if (r) exp_q.push_back(ex);
  endtask
  always @(negedge clk_sys) if (rd_seen) chk("rdata", 24'(reg_rdata), 24'(exp_q.pop_front()));
  initial begin
    #20us;
    error_cnt++;
    end_of_test;
  end
  // ==========
  // Scenarios
  initial begin
    void'($urandom(32'hd498));
    repeat (16) @(negedge clk_sys);
    nrst = 1;
    op(0, 1, 8'h1b, 8'h00, `HDC_DRIVE_CTRL_RST);
    op(0, 0, 8'h00, 8'h00, 8'h00);
    chk("type", 24'(actuator_type_select), 24'd0);
    chk("half", drive_half_period, 24'd300000);
    chk("bemf", bemf_sample_period, 24'd600000);
    repeat (8) begin
      d = 8'($urandom);
      overdrive_phase = 1'($urandom);
      op(1, 0, 8'h1b, d, 8'h00);
      op(0, 1, 8'h1b, 8'h00, d & `HDC_DRIVE_CTRL_MASK);
      op(0, 0, 8'h00, 8'h00, 8'h00);
      @(negedge clk_sys);
      chk("bias", 24'(input_trigger_pin_bias_en), 24'(d[5]));
      chk("bemf", bemf_sample_period, (d[4:0] * 24'd200 + 24'd1000) * 24'd125);
      chk("gain", 24'(high_loop_gain), 24'(d[7] & overdrive_phase));
    end
    op(1, 0, 8'h1a, 8'h80, 8'h00);
    op(1, 0, 8'h5c, 8'hff, 8'h00);
    op(0, 1, 8'h5c, 8'h00, 8'h00);
    op(0, 1, 8'h1b, 8'h00, d & `HDC_DRIVE_CTRL_MASK);
    exp_half = (d[4:0] * 24'd100 + 24'd500) * 24'd125;
    repeat (200) begin
      op(0, 0, 8'h00, 8'h00, 8'h00);
      chk("half", drive_half_period, exp_half);
      chk("tick", 24'(bemf_sample_tick), 24'd0);
      resonance_early = 1'($urandom);
      resonance_late = 1'($urandom);
      if (resonance_early && exp_half > 24'd13) exp_half = exp_half - 24'd12;
      else if (resonance_late && exp_half < 24'd387500) exp_half = exp_half + 24'd12;
    end
    chk("type", 24'(actuator_type_select), 24'd1);
    nrst = 0;
    @(negedge clk_sys);
    nrst = 1;
    op(0, 1, 8'h1b, 8'h00, `HDC_DRIVE_CTRL_RST);
    op(0, 0, 8'h00, 8'h00, 8'h00);
    @(negedge clk_sys);
    chk("type", 24'(actuator_type_select), 24'd0);
    chk("half", drive_half_period, 24'd300000);
    end_of_test;
  end
endmodule // test_haptic_drive_control_reg
bind hdc_drive_control hdc_drive_control_properties chk_i (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .overdrive_phase(overdrive_phase),
  .high_loop_gain(high_loop_gain),
  .input_trigger_pin_bias_en(input_trigger_pin_bias_en),
  .actuator_type_select(actuator_type_select),
  .bemf_sample_tick(bemf_sample_tick),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .drive_half_period(drive_half_period),
  .bemf_sample_period(bemf_sample_period)
);
